// ### pkg/watch_pkg.sv
// constants and carrier types for the watch timer with prescaler
package watch_pkg;

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W          = 8;
  localparam int unsigned WT_CNT_W       = 15;
  localparam logic [7:0]  CNT_ZERO       = 8'h00;
  localparam logic [7:0]  CNT_ONE        = 8'h01;
  localparam logic [14:0] WT_ZERO        = 15'h0000;
  localparam logic [14:0] WT_ONE         = 15'h0001;
  localparam logic [1:0]  WATCH_RUN      = 2'h3;
  localparam logic [1:0]  SRC_SUB        = 2'h0;
  // last count of the half-second period of 16384 watch-clock ticks
  localparam logic [14:0] HALF_SEC_TICKS = 15'h3fff;
  // first-period head start before the half-second chain
  localparam logic [14:0] FIRST_PRE      = 15'h01ff;
  localparam int unsigned SUB_HZ         = 32768;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       output_disable;
    logic [1:0] clock_select;
    logic       enable;
  } prescaler_mode_type;

  typedef struct packed {
    logic [5:0] config_field;
    logic       control_bit1;
    logic       control_bit0;
  } watch_mode_type;

endpackage : watch_pkg

// ### rtl/watch_timer_with_prescaler.sv
// watch timer with baud-rate interval timer prescaler
`timescale 1ns/100ps
module watch_timer_with_prescaler
  import watch_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire prescaler_mode_type prescaler_mode_reg,
  input  wire logic [CNT_W-1:0]   prescaler_compare_reg,
  input  wire watch_mode_type     watch_mode_reg,
  input  wire logic               subclock_in,
  input  wire logic               irq_ack,
  output logic                    prescaler_tick,
  output logic                    prescaler_out,
  output logic                    watch_interrupt,
  output logic                    watch_pending
);

  // ----------------------------------------------------------------
  // subclock synchroniser and edge detect
  // ----------------------------------------------------------------
  logic sub_meta_r, sub_sync_r, sub_prev_r;
  logic sub_meta_nxt, sub_sync_nxt, sub_prev_nxt;
  logic sub_rise;
  // only the second and third flops feed logic; the first may still be settling

  always_comb
  begin
    sub_meta_nxt = subclock_in;
    sub_sync_nxt = sub_meta_r;
    sub_prev_nxt = sub_sync_r;
    sub_rise     = sub_sync_r & ~sub_prev_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_meta_r <= 1'b0;
      sub_sync_r <= 1'b0;
      sub_prev_r <= 1'b0;
    end
    else
    begin
      sub_meta_r <= sub_meta_nxt;
      sub_sync_r <= sub_sync_nxt;
      sub_prev_r <= sub_prev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // settings are used live; software keeps them still while running
  logic [CNT_W-1:0] pre_cnt_r, pre_cnt_nxt;
  logic             tick_r, tick_nxt;
  // the compare value is read live, so a mid-run load bends one period

  always_comb
  begin
    pre_cnt_nxt = pre_cnt_r;
    tick_nxt    = 1'b0;
    if (!prescaler_mode_reg.enable)
    begin
      pre_cnt_nxt = CNT_ZERO;
    end
    else if (pre_cnt_r >= prescaler_compare_reg)
    begin
      pre_cnt_nxt = CNT_ZERO;
      tick_nxt    = 1'b1;
    end
    else
    begin
      pre_cnt_nxt = pre_cnt_r + CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_r <= CNT_ZERO;
      tick_r    <= 1'b0;
    end
    else
    begin
      pre_cnt_r <= pre_cnt_nxt;
      tick_r    <= tick_nxt;
    end
  end

  // ----------------------------------------------------------------
  // prescaler output pin
  // ----------------------------------------------------------------
  // the pin parks low while stopped; disable only silences the pin
  logic pout_r, pout_nxt;

  always_comb
  begin
    pout_nxt = pout_r;
    if (!prescaler_mode_reg.enable)
      pout_nxt = 1'b0;
    else if (tick_nxt)
      pout_nxt = ~pout_r & ~prescaler_mode_reg.output_disable;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pout_r <= 1'b0;
    end
    else
    begin
      pout_r <= pout_nxt;
    end
  end

  // ----------------------------------------------------------------
  // watch counter
  // ----------------------------------------------------------------
  logic                watch_tick;
  logic                running;
  logic [WT_CNT_W-1:0] wt_cnt_r, wt_cnt_nxt;
  logic                first_r, first_nxt;
  logic                irq_r, irq_nxt;

  // main-clock source needs the prescaler near 32.768 kHz
  always_comb
  begin
    watch_tick = (prescaler_mode_reg.clock_select == SRC_SUB) ? sub_rise
                                                              : tick_r;
    running    = {watch_mode_reg.control_bit1,
                  watch_mode_reg.control_bit0} == WATCH_RUN;
  end

  always_comb
  begin
    wt_cnt_nxt = wt_cnt_r;
    first_nxt  = first_r;
    irq_nxt    = 1'b0;
    if (!running)
    begin
      // clearing bit 0 loses phase, so software avoids it mid-run
      wt_cnt_nxt = WT_ZERO;
      first_nxt  = 1'b1;
    end
    else if (watch_tick)
    begin
      // first period runs the head start, then a full half second
      // the head start is fixed at its longest allowed length
      if (first_r && wt_cnt_r == FIRST_PRE)
      begin
        wt_cnt_nxt = WT_ZERO;
        first_nxt  = 1'b0;
      end
      else if (!first_r && wt_cnt_r == HALF_SEC_TICKS)
      begin
        wt_cnt_nxt = WT_ZERO;
        irq_nxt    = 1'b1;
      end
      else
      begin
        wt_cnt_nxt = wt_cnt_r + WT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wt_cnt_r <= WT_ZERO;
      first_r  <= 1'b1;
      irq_r    <= 1'b0;
    end
    else
    begin
      wt_cnt_r <= wt_cnt_nxt;
      first_r  <= first_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pending flag
  // ----------------------------------------------------------------
  // the flag outlives the one-cycle pulse until the controller acks it;
  // a fresh request wins over an acknowledge landing in the same cycle
  logic pend_r, pend_nxt;

  always_comb
  begin
    pend_nxt = pend_r;
    if (irq_ack)
      pend_nxt = 1'b0;
    if (irq_nxt)
      pend_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
    end
  end

  // outputs come straight from their flops
  always_comb
  begin
    prescaler_tick  = tick_r;
    prescaler_out   = pout_r;
    watch_interrupt = irq_r;
    watch_pending   = pend_r;
  end

endmodule : watch_timer_with_prescaler

// ### tb/watch_chk_assertions.sv
// assertions on the watch timer ports
`timescale 1ns/100ps
module watch_chk
  import watch_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire prescaler_mode_type prescaler_mode_reg,
  input wire logic [CNT_W-1:0]   prescaler_compare_reg,
  input wire watch_mode_type     watch_mode_reg,
  input wire logic               irq_ack,
  input wire logic               prescaler_tick,
  input wire logic               prescaler_out,
  input wire logic               watch_interrupt,
  input wire logic               watch_pending
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // gap counter, only with one watch tick per cycle
  // ----------------------------------------
  logic        run;
  logic        fast;
  logic [16:0] st_r;
  logic [16:0] st_nxt;
  assign run  = watch_mode_reg.control_bit1 & watch_mode_reg.control_bit0;
  assign fast = run & prescaler_mode_reg.enable
              & (prescaler_compare_reg == 8'h00)
              & (prescaler_mode_reg.clock_select != 2'h0);
  always_comb
    if (!fast) st_nxt = 17'h1_0000;
    else if (watch_interrupt) st_nxt = 17'h0_0001;
    else st_nxt = st_r + 17'h0_0001;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) st_r <= 17'h1_0000;
    else st_r <= st_nxt;
  sequence s_run_start;
    $rose(run);
  endsequence
  property p_hold; (!prescaler_mode_reg.enable)[*2] |=> !prescaler_tick;
  endproperty
  property p_late; s_run_start |=> (!watch_interrupt)[*8]; endproperty
  property p_first; watch_interrupt && fast && st_r[16] |->
    st_r[15:0] >= 16'h4000 && st_r[15:0] <= 16'h4218; endproperty
  property p_period; watch_interrupt && !st_r[16] |->
    st_r[15:0] == 16'h4000; endproperty
  property p_pend; watch_interrupt |-> watch_pending; endproperty
  property p_pulse; watch_interrupt |=> !watch_interrupt; endproperty
  // an acknowledge clears the flag unless a fresh request lands with it
  property p_ack; watch_pending && irq_ack |=>
    watch_pending == watch_interrupt; endproperty
  property p_idle; !prescaler_mode_reg.enable |=> !prescaler_out;
  endproperty
  property p_toggle; prescaler_tick &&
    !$past(prescaler_mode_reg.output_disable) |->
    prescaler_out != $past(prescaler_out); endproperty
  property p_park; prescaler_tick &&
    $past(prescaler_mode_reg.output_disable) |-> !prescaler_out;
  endproperty
  a_hold: assert property (p_hold) else $error("tick while stopped");
  a_late: assert property (p_late) else $error("early interrupt");
  a_first: assert property (p_first) else $error("first gap");
  a_period: assert property (p_period) else $error("period gap");
  a_pend: assert property (p_pend) else $error("pending not set");
  a_pulse: assert property (p_pulse) else $error("long pulse");
  a_ack: assert property (p_ack) else $error("pending kept");
  a_idle: assert property (p_idle) else $error("pin not low");
  a_toggle: assert property (p_toggle) else $error("pin stuck");
  a_park: assert property (p_park) else $error("pin not parked");
endmodule : watch_chk
bind watch_timer_with_prescaler watch_chk chk_u (.*);

// ### tb/watch_timer_with_prescaler_tb_top.sv
// self-checking bench for the watch timer
`timescale 1ns/100ps
module watch_timer_with_prescaler_tb_top import watch_pkg::*;;
  logic ref_clk = 1'b0, rst_n = 1'b0, ack = 1'b0, tick, wi, wp, pout;
  logic sub = 1'b0, sub_run = 1'b0, od = 1'b0;
  prescaler_mode_type pm = '0;
  watch_mode_type     wm = '0;
  logic [7:0]         cmp = 8'h00;
  int n_errors = 0, compares = 0, d1, d2;
  watch_timer_with_prescaler dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .prescaler_mode_reg(pm), .prescaler_compare_reg(cmp),
    .watch_mode_reg(wm), .subclock_in(sub), .irq_ack(ack),
    .prescaler_tick(tick), .prescaler_out(pout), .watch_interrupt(wi),
    .watch_pending(wp));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task drive(input logic en, input logic [1:0] cs, input logic [7:0] c,
             input logic [1:0] ctl);
    @(negedge ref_clk);
    pm  = {od, cs, en};
    cmp = c;
    wm  = {6'h2a, ctl};
  endtask : drive
  task count_to(input bit w, output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (((w ? wi : tick) !== 1'b1) && n < 40000);
    // a search that runs out is a failure in its own right
    if (n >= 40000)
      n_errors++;
  endtask : count_to
  task check(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task final_report;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    forever
    begin
      @(negedge ref_clk);
      if (sub_run)
        sub = ~sub;
    end
  end
  initial
  begin
    #640000;
    n_errors++;
    final_report();
  end
  initial
  begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    drive(1'b0, 2'h1, 8'hff, 2'h0);
    drive(1'b1, 2'h1, 8'hff, 2'h0);
    count_to(1'b0, d1);
    check("first tick", 16'(d1), 16'h0100);
    repeat (100) @(negedge ref_clk);
    drive(1'b0, 2'h1, 8'hff, 2'h0);
    drive(1'b1, 2'h1, 8'hff, 2'h0);
    count_to(1'b0, d2);
    check("restart", 16'(d2), 16'(d1));
    check("pin high", 16'(pout), 16'h0001);
    count_to(1'b0, d2);
    check("period", 16'(d2), 16'h0100);
    check("pin low", 16'(pout), 16'h0000);
    drive(1'b0, 2'h1, 8'hff, 2'h0);
    od = 1'b1;
    drive(1'b0, 2'h1, 8'hff, 2'h0);
    drive(1'b1, 2'h1, 8'hff, 2'h0);
    count_to(1'b0, d2);
    check("pin parked", 16'(pout), 16'h0000);
    drive(1'b0, 2'h1, 8'hff, 2'h0);
    od = 1'b0;
    $display("prescaler test done");
    drive(1'b0, 2'h1, 8'h00, 2'h0);
    drive(1'b1, 2'h1, 8'h00, 2'h0);
    drive(1'b1, 2'h1, 8'h00, 2'h3);
    count_to(1'b1, d1);
    check("first", 16'(d1 > 16'h4000 && d1 <= 16'h4218), 16'h0001);
    count_to(1'b1, d2);
    check("interval", 16'(d2), 16'h4000);
    check("pending", 16'(wp), 16'h0001);
    @(negedge ref_clk);
    ack = 1'b1;
    @(negedge ref_clk);
    ack = 1'b0;
    check("cleared", 16'(wp), 16'h0000);
    $display("watch test done");
    drive(1'b1, 2'h1, 8'h00, 2'h0);
    drive(1'b0, 2'h1, 8'h00, 2'h0);
    drive(1'b0, 2'h0, 8'h00, 2'h0);
    sub_run = 1'b1;
    drive(1'b0, 2'h0, 8'h00, 2'h3);
    count_to(1'b1, d1);
    check("sub first", 16'(d1 > 16'h8000 && d1 <= 16'h8430), 16'h0001);
    $display("subclock test done");
    final_report();
  end
endmodule : watch_timer_with_prescaler_tb_top
